// ### sac_sequencer.v
// sequencer and register file of an 8-bit successive-approximation
// converter with a 16-way input multiplexer, reached over AXI4-Lite.
// assumes a latched comparator whose output is clocked by aclk and
// a deep stop level from the on-chip power controller on aclk.
//
// Operation
// - setting on starts continuous conversion
// - conversion lasts twelve half-rate converter clocks
// - load phase, then eight approximation steps
// - phases repeat back to back while on
// - capacitor keeps previous charge after conversion
// - completion sets done flag, no interrupt
// - result holds until next conversion completes
// - control write while on aborts, restarts unless it clears on
// - input at high reference gives full scale
// - input at low reference gives zero
// - core idle leaves converter unchanged
// - deep stop disables, then settling delay
// - clearing on stops conversion, saves power
// - result read or control write clears done
// - result register read-only, resets to zero
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`include "sac_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module sac_sequencer #(
  parameter ADDR_W = 12,
  parameter STAB_CYCLES = `SAC_STAB_CYCLES_DEF
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [ADDR_W-1:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire comp_in,
  input wire deep_stop,
  output reg [3:0] chan_sel,
  output reg sample_en,
  output reg [7:0] dac_code,
  output reg conv_power,
  output wire irq
);

  // integer forms first, then cut to the counter widths on purpose
  localparam integer LOAD_I = `SAC_LOAD_CYCLES;
  localparam integer LAST_I = `SAC_CONV_CYCLES - 1;
  localparam integer STAB_I = STAB_CYCLES - 1;
  localparam [4:0] LOAD_CYC = LOAD_I[4:0];
  localparam [4:0] LAST_CYC = LAST_I[4:0];
  localparam [15:0] STAB_LAST = STAB_I[15:0];

  // software-visible state
  reg [3:0] chan_q;
  reg on_q;
  reg done_q;
  reg [7:0] result_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_en_q;

  // sequencer state
  reg [4:0] cyc_q;
  reg [7:0] sar_q;
  reg [15:0] stab_q;
  reg stab_busy_q;
  reg stop_q;

  // axi write side holding registers
  reg aw_have_q;
  reg w_have_q;
  reg [9:0] aw_idx_q;
  reg [7:0] wd_q;
  reg ws_q;

  wire wr_go;
  wire csr_wr;
  wire en_wr;
  wire clr_wr;
  wire wr_map;
  wire rd_go;
  wire [9:0] ar_idx;
  wire res_rd;
  wire run;
  wire approx;
  wire [4:0] cyc_m;
  wire [7:0] mask;
  wire done_evt;
  wire abort_evt;
  wire stable_evt;
  wire [1:0] irq_set;

  // write address and data are taken independently, in any order
  assign awready = !aw_have_q && !bvalid;
  assign wready = !w_have_q && !bvalid;
  assign wr_go = aw_have_q && w_have_q;
  assign csr_wr = wr_go && ws_q && (aw_idx_q == `SAC_IDX_CSR);
  assign en_wr = wr_go && ws_q && (aw_idx_q == `SAC_IDX_IRQ_EN);
  assign clr_wr = wr_go && ws_q && (aw_idx_q == `SAC_IDX_IRQ_CLR);
  assign wr_map = (aw_idx_q == `SAC_IDX_CSR) ||
                  (aw_idx_q == `SAC_IDX_IRQ_EN) ||
                  (aw_idx_q == `SAC_IDX_IRQ_CLR);

  // one read at a time; a new one waits for the answer to drain
  assign arready = !rvalid;
  assign rd_go = arvalid && arready;
  assign ar_idx = araddr[11:2];
  assign res_rd = rd_go && (ar_idx == `SAC_IDX_RESULT);

  // converter runs only when on, awake and settled
  assign run = on_q && !stop_q && !stab_busy_q;
  assign approx = (cyc_q >= LOAD_CYC);
  assign cyc_m = cyc_q - LOAD_CYC;
  assign mask = 8'h80 >> cyc_m[3:1];

  // a control write while running aborts, so an abort beats a completion
  assign done_evt = run && !csr_wr && (cyc_q == LAST_CYC);
  assign abort_evt = csr_wr && run;
  assign stable_evt = stab_busy_q && (stab_q == STAB_LAST);
  assign irq_set = {stable_evt, abort_evt};

  // level interrupt from enabled sticky bits; completion never feeds it
  assign irq = |(irq_stat_q & irq_en_q);

  // write channel capture
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 10'h000;
      wd_q <= 8'h00;
      ws_q <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_have_q <= 1'b1;
        aw_idx_q <= awaddr[11:2];
      end
      else if (wr_go)
        aw_have_q <= 1'b0;
      if (wvalid && wready)
      begin
        w_have_q <= 1'b1;
        wd_q <= wdata[7:0];
        ws_q <= wstrb[0]; // only lane 0 carries register bits
      end
      else if (wr_go)
        w_have_q <= 1'b0;
    end
  end

  // write response, unmapped or read-only targets answer slverr
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= `SAC_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      bresp <= wr_map ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
    end
    else if (bvalid && bready)
      bvalid <= 1'b0;
  end

  // read data is registered; reserved bits read as zero
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `SAC_RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid <= 1'b1;
      rresp <= `SAC_RESP_OKAY;
      case (ar_idx)
        `SAC_IDX_RESULT: rdata <= {24'h000000, result_q};
        `SAC_IDX_CSR: rdata <= {24'h000000, done_q, 1'b0, on_q, 1'b0,
                                chan_q};
        `SAC_IDX_IRQ_STAT: rdata <= {30'h00000000, irq_stat_q};
        `SAC_IDX_IRQ_EN: rdata <= {30'h00000000, irq_en_q};
        default:
        begin
          rdata <= 32'h00000000;
          rresp <= `SAC_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  // control register; channel and on bit are plain software fields
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chan_q <= `SAC_CHAN_RESET;
      on_q <= 1'b0;
    end
    else if (csr_wr)
    begin
      chan_q <= wd_q[`SAC_CSR_CH_MSB:`SAC_CSR_CH_LSB];
      on_q <= wd_q[`SAC_CSR_ON_BIT];
    end
  end

  // done flag: a result read loses to a completion in the same cycle
  always @(posedge aclk)
  begin
    if (!aresetn)
      done_q <= 1'b0;
    else if (done_evt)
      done_q <= 1'b1;
    else if (csr_wr || res_rd)
      done_q <= 1'b0;
  end

  // interrupt enable and sticky status, set wins over clear
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_en_q <= `SAC_IRQ_RESET;
      irq_stat_q <= `SAC_IRQ_RESET;
    end
    else
    begin
      if (en_wr)
        irq_en_q <= wd_q[1:0];
      if (clr_wr)
        irq_stat_q <= (irq_stat_q & ~wd_q[1:0]) | irq_set;
      else
        irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  // deep stop tracking and settling count after wake-up
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stop_q <= 1'b0;
      stab_busy_q <= 1'b0;
      stab_q <= 16'h0000;
    end
    else
    begin
      stop_q <= deep_stop;
      if (deep_stop)
      begin
        stab_busy_q <= 1'b0;
        stab_q <= 16'h0000;
      end
      else if (stop_q)
      begin
        stab_busy_q <= 1'b1;
        stab_q <= 16'h0000;
      end
      else if (stable_evt)
        stab_busy_q <= 1'b0;
      else if (stab_busy_q)
        stab_q <= stab_q + 16'h0001;
    end
  end

  // conversion sequencer: aclk pairs form one converter clock period
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cyc_q <= 5'h00;
      sar_q <= 8'h00;
      result_q <= `SAC_RESULT_RESET;
    end
    else if (!run || csr_wr)
    begin
      // off, stopped or rewritten: hold at the start of a conversion
      cyc_q <= 5'h00;
      sar_q <= 8'h00;
    end
    else
    begin
      if (approx)
      begin
        // even cycle tries the bit, odd cycle keeps or drops it
        if (!cyc_q[0])
          sar_q <= sar_q | mask;
        else if (!comp_in)
          sar_q <= sar_q & ~mask;
      end
      if (cyc_q == LAST_CYC)
      begin
        // result changes only here, so it stays valid between ends
        result_q <= comp_in ? sar_q : (sar_q & ~mask);
        // next conversion starts from a cleared trial code
        sar_q <= 8'h00;
        cyc_q <= 5'h00;
      end
      else
        cyc_q <= cyc_q + 5'h01;
    end
  end

  // analog side drive; capacitor only connected in the load phase
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chan_sel <= 4'h0;
      sample_en <= 1'b0;
      dac_code <= 8'h00;
      conv_power <= 1'b0;
    end
    else
    begin
      chan_sel <= chan_q;
      // a control write reaches the power rail at once
      conv_power <= (csr_wr ? wd_q[`SAC_CSR_ON_BIT] : on_q) &&
                    !deep_stop;
      // no discharge between conversions saves pin current;
      // a restart keeps the capacitor on the input through reload
      sample_en <= run &&
                   (csr_wr ? wd_q[`SAC_CSR_ON_BIT] : !approx);
      // bit under test goes out at once, so the comparator
      // answers for this trial by the odd edge that decides it
      if (run && !csr_wr && approx && !cyc_q[0])
        dac_code <= sar_q | mask;
      else
        dac_code <= sar_q;
    end
  end

endmodule // sac_sequencer

`default_nettype wire

// ### sac_consts.vh
// register map, field positions, reset values and timing counts
// for the successive-approximation converter sequencer.
// assumes a 50 MHz aclk and word-aligned AXI4-Lite access.
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

// register indices; byte address is four times the index
`define SAC_IDX_RESULT 10'h070
`define SAC_IDX_CSR 10'h071
`define SAC_IDX_IRQ_STAT 10'h072
`define SAC_IDX_IRQ_EN 10'h073
`define SAC_IDX_IRQ_CLR 10'h074

// control/status field positions
`define SAC_CSR_DONE_BIT 7
`define SAC_CSR_ON_BIT 5
`define SAC_CSR_CH_MSB 3
`define SAC_CSR_CH_LSB 0

// reset values
`define SAC_CSR_RESET 8'h00
`define SAC_CHAN_RESET 4'h0
`define SAC_RESULT_RESET 8'h00
`define SAC_IRQ_RESET 2'h0

// interrupt status bit positions
`define SAC_IRQ_ABORT_BIT 0
`define SAC_IRQ_STABLE_BIT 1

// converter timing: aclk cycles per converter clock, then phase lengths in converter clock periods
`define SAC_ADC_DIV 2
`define SAC_LOAD_PERIODS 4
`define SAC_APPROX_PERIODS 8
`define SAC_CONV_PERIODS 12

// the same timing in aclk cycles
`define SAC_LOAD_CYCLES (`SAC_LOAD_PERIODS * `SAC_ADC_DIV)
`define SAC_CONV_CYCLES (`SAC_CONV_PERIODS * `SAC_ADC_DIV)

// default settling time after deep stop, in aclk cycles
`define SAC_STAB_CYCLES_DEF 256

// axi responses
`define SAC_RESP_OKAY 2'b00
`define SAC_RESP_SLVERR 2'b10

`endif

// ### sac_checker.sv
// port checker for the converter sequencer
// assumes one aclk domain with a sync active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.vh"
module sac_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  input wire logic deep_stop,
  input wire logic sample_en,
  input wire logic [7:0] dac_code,
  input wire logic conv_power,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_off_idle;
    !conv_power [*2] |-> !sample_en;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("sampling while off");
  property p_load_on;
    sample_en |-> $past(conv_power);
  endproperty
  a_load_on: assert property (p_load_on)
    else $error("sampling without power");
  property p_load_len;
    $fell(sample_en) && conv_power |-> $past(sample_en, 8);
  endproperty
  a_load_len: assert property (p_load_len)
    else $error("load phase too short");
  property p_repeat;
    $fell(sample_en) |-> ##[1:17] (sample_en || !conv_power);
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("no next conversion");
  property p_msb;
    $fell(sample_en) && conv_power |-> ##[0:2] dac_code == 8'h80;
  endproperty
  a_msb: assert property (p_msb)
    else $error("first trial not msb");
  property p_deep;
    deep_stop |=> !conv_power;
  endproperty
  a_deep: assert property (p_deep)
    else $error("powered in deep stop");
  property p_res_wr;
    awvalid && awready && wvalid && wready &&
      awaddr == {`SAC_IDX_RESULT, 2'b00}
      |-> ##2 bvalid && bresp == `SAC_RESP_SLVERR;
  endproperty
  a_res_wr: assert property (p_res_wr)
    else $error("result write accepted");
  property p_irq0;
    $rose(aresetn) |-> !irq;
  endproperty
  a_irq0: assert property (p_irq0)
    else $error("irq out of reset");
endmodule // sac_checker
bind sac_sequencer sac_checker u_chk (.aclk, .aresetn, .awaddr,
  .awvalid, .awready, .wvalid, .wready, .bvalid, .bresp, .deep_stop,
  .sample_en, .dac_code, .conv_power, .irq);
`default_nettype wire

// ### sac_comp_model.sv
// comparator model on the far side of the converter
// assumes the trial code settles within one aclk cycle
`timescale 1ns/1ps
`default_nettype none
module sac_comp_model (
  input wire logic [3:0] chan_sel,
  input wire logic [7:0] dac_code,
  output logic comp_in
);
  // odd inputs at the high reference, even ones at the low
  wire [7:0] level = chan_sel[0] ? 8'hff : 8'h00;
  // ideal comparator, no offset
  assign comp_in = level >= dac_code;
endmodule // sac_comp_model
`default_nettype wire

// ### sac_sequencer_bench.sv
// self-checking bench for the converter sequencer
// assumes the comparator model and a 50 MHz aclk
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module sac_sequencer_bench;
  localparam [11:0] A_RES = {`SAC_IDX_RESULT, 2'b00};
  localparam [11:0] A_CSR = {`SAC_IDX_CSR, 2'b00};
  localparam [11:0] A_ST = {`SAC_IDX_IRQ_STAT, 2'b00};
  localparam [11:0] A_EN = {`SAC_IDX_IRQ_EN, 2'b00};
  localparam [11:0] A_CLR = {`SAC_IDX_IRQ_CLR, 2'b00};
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, deep_stop = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, comp_in, sample_en;
  wire conv_power, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] chan_sel;
  wire [7:0] dac_code;
  int mismatches = 0, compares = 0, cyc = 0;
  sac_sequencer #(.STAB_CYCLES(4)) dut (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .comp_in, .deep_stop, .chan_sel, .sample_en,
    .dac_code, .conv_power, .irq);
  sac_comp_model u_cmp (.chan_sel, .dac_code, .comp_in);
  always #10 aclk = ~aclk;
  // hang guard, whole run is well under a thousand cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // address and data offered together, each dropped when taken
  task wr(input [11:0] a, input [31:0] v);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bready && bvalid)
      begin
        bready <= 0;
        r = bresp;
      end
    end
    while (awvalid || wvalid || bready);
  endtask
  task rd(input [11:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rready && rvalid)
      begin
        rready <= 0;
        d = rdata;
        r = rresp;
      end
    end
    while (rready);
  endtask
  // polls the flag, bounded; a conversion is 24 cycles
  task poll;
    repeat (20)
    begin
      rd(A_CSR);
      if (d[7] === 1'b1) break;
    end
    `CHK(d[7], 1'b1)
  endtask
  task t_conv;
    rd(A_RES);
    `CHK(d, 32'h0)
    wr(A_CSR, 32'h21);
    poll;
    `CHK(chan_sel, 4'h1)
    `CHK(irq, 1'b0)
    rd(A_RES);
    `CHK(d[7:0], 8'hff)
    rd(A_CSR);
    `CHK(d[7], 1'b0)
    poll;
    wr(A_CSR, 32'h20);
    poll;
    rd(A_RES);
    `CHK(d[7:0], 8'h00)
    $display("conversion test done");
  endtask
  task t_abort;
    wr(A_CLR, 32'h3);
    wr(A_EN, 32'h1);
    `CHK(irq, 1'b0)
    poll;
    wr(A_CSR, 32'h20);
    rd(A_CSR);
    `CHK(d[7], 1'b0)
    `CHK(irq, 1'b1)
    wr(A_CLR, 32'h1);
    `CHK(irq, 1'b0)
    wr(A_EN, 32'h0);
    wr(A_CSR, 32'h20);
    rd(A_ST);
    `CHK(d[0], 1'b1)
    `CHK(irq, 1'b0)
    wr(A_CLR, 32'h1);
    $display("abort test done");
  endtask
  task t_power;
    wr(A_CSR, 32'h0);
    repeat (30) @(posedge aclk);
    rd(A_CSR);
    `CHK(d[7], 1'b0)
    `CHK(conv_power, 1'b0)
    wr(A_CSR, 32'h21);
    deep_stop <= 1;
    repeat (3) @(posedge aclk);
    `CHK(conv_power, 1'b0)
    deep_stop <= 0;
    repeat (10) @(posedge aclk);
    rd(A_ST);
    `CHK(d[1], 1'b1)
    poll;
    rd(A_RES);
    `CHK(d[7:0], 8'hff)
    $display("power test done");
  endtask
  task t_bus;
    rd(12'h000);
    `CHK(r, `SAC_RESP_SLVERR)
    wr(A_RES, 32'h55);
    `CHK(r, `SAC_RESP_SLVERR)
    rd(A_RES);
    `CHK(d[7:0], 8'hff)
    $display("bus test done");
  endtask
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    t_conv;
    t_abort;
    t_power;
    t_bus;
    tally_and_finish;
  end
endmodule // sac_sequencer_bench
`default_nettype wire
